/* rtl/cdg_map.vh */
/*
 * constants for the complementary dead-band generator: control field
 * widths, reset values and timing figures.
 * assumes a single 40 MHz system clock and no register bus.
 */
// Function
// - dead bands are timed from system clock or the 16 MHz internal oscillator.
// - clock select 1 picks internal oscillator, 0 picks system clock.
// - three-bit select picks one of eight input sources.
// - both drives are cleared right after module enable is set.
// - each output has an enable; clear leaves pin undriven.
// - module enable clear makes output enables and levels ineffective.
// - polarity bit set means active-high, clear means active-low.
// - override levels go to pins without polarity applied.
// - two independent 6-bit counters, one per input edge direction.
// - dead band counts clock periods from zero up to programmed value.
// - rising edge drops B at once, raises A after rising count.
// - falling edge drops A at once, raises B after falling count.
// - rising duration comes from the rising dead-band register, 0 to 64; the six-bit register here holds 0 to 63.
// - falling duration comes from the falling dead-band register, up to 64; the six-bit register here holds up to 63.
// - zero programmed means no dead time, output switches at the edge.
// - input returning early means waiting output never turns on.
// - edges may be asynchronous; dead-time error at most one clock period.
`ifndef CDG_MAP_VH
`define CDG_MAP_VH

`define CDG_DB_WIDTH        6
`define CDG_SEL_WIDTH       3
`define CDG_DB_RESET        6'h00
`define CDG_SYS_CLOCK_HZ    40000000
`define CDG_FAST_OSC_HZ     16000000
`define CDG_CLK_SEL_FAST    1'b1
`define CDG_CLK_SEL_SYS     1'b0
`define CDG_ACC_WIDTH       24
`define CDG_ACC_INC         24'h66_6666
`define CDG_DRV_ACT_A       2'h1
`define CDG_DRV_ACT_B       2'h2

`endif

/* rtl/cdg_sync.v */
/*
 * two-flop synchroniser for a level arriving from another domain.
 * assumes one receiving clock; the first stage feeds only the second.
 */
module cdg_sync (
  input  wire clock,
  input  wire reset_n,
  input  wire level_in,
  output reg  level_out
);

  reg stage_one;

  // ****************************************
  // two-stage capture
  // ****************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage_one <= 1'b0;
      level_out <= 1'b0;
    end else begin
      stage_one <= level_in;
      level_out <= stage_one;
    end
  end

endmodule // cdg_sync

/* rtl/cdg_tick.v */
/*
 * fractional divider making a one-cycle enable at about 16 MHz from the
 * 40 MHz system clock, standing in for the internal fast oscillator.
 * assumes the system clock rate in the map header.
 */
`include "cdg_map.vh"

module cdg_tick (
  input  wire clock,
  input  wire reset_n,
  input  wire run,
  output reg  tick
);

  reg [`CDG_ACC_WIDTH-1:0] acc;
  wire [`CDG_ACC_WIDTH:0]  next_acc;

  // phase accumulator; carry out marks one fast-oscillator period
  assign next_acc = {1'b0, acc} + {1'b0, `CDG_ACC_INC};

  // ****************************************
  // accumulator and enable pulse
  // ****************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc  <= {`CDG_ACC_WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (!run) begin
      acc  <= {`CDG_ACC_WIDTH{1'b0}};
      tick <= 1'b0;
    end else begin
      acc  <= next_acc[`CDG_ACC_WIDTH-1:0];
      tick <= next_acc[`CDG_ACC_WIDTH];
    end
  end

endmodule // cdg_tick

/* rtl/cdg_gen.v */
/*
 * complementary waveform generator with independent rising and falling
 * dead bands, input source select, polarity, pin enables and override.
 * assumes asynchronous source inputs and static control bits set by
 * software; the override levels and override-active come from shutdown
 * logic outside this block.
 * timing seen from a source pin: two cycles of synchroniser, edge compare
 * in the same cycle as the drive registers, then the pin registers.
 * with the system clock selected a dead band of n holds the waiting pin
 * off for n cycles; with the fast tick selected it holds it for n ticks,
 * give or take one tick, since the edge can land anywhere within a tick.
 * a dead-band value of 64 cannot be held in six bits; 63 is the largest.
 */
`include "cdg_map.vh"

module cdg_gen (
  input  wire                      clock,
  input  wire                      reset_n,
  input  wire                      module_enable,
  input  wire                      out_a_pin_enable,
  input  wire                      out_b_pin_enable,
  input  wire                      out_a_polarity,
  input  wire                      out_b_polarity,
  input  wire                      deadband_clock_select,
  input  wire [`CDG_SEL_WIDTH-1:0] input_source_select,
  input  wire [`CDG_DB_WIDTH-1:0]  rising_deadtime_reg,
  input  wire [`CDG_DB_WIDTH-1:0]  falling_deadtime_reg,
  input  wire                      comparator_one_sync_out,
  input  wire                      comparator_two_sync_out,
  input  wire                      pulse_gen_one_out,
  input  wire                      pulse_gen_two_out,
  input  wire                      pulse_gen_three_out,
  input  wire                      pulse_gen_four_out,
  input  wire                      numeric_oscillator_out,
  input  wire                      logic_cell_one_out,
  input  wire                      override_active,
  input  wire                      override_level_a,
  input  wire                      override_level_b,
  output reg                       primary_output,
  output reg                       primary_output_oe,
  output reg                       complement_output,
  output reg                       complement_output_oe,
  output wire [`CDG_DB_WIDTH-1:0]  deadband_count,
  output wire                      deadband_busy
);

  // states of the edge sequencer
  localparam ST_IDLE = 2'h0;
  localparam ST_RISE = 2'h1;
  localparam ST_FALL = 2'h2;

  // source select codes
  localparam SRC_CMP_ONE   = 3'h0;
  localparam SRC_CMP_TWO   = 3'h1;
  localparam SRC_PWM_ONE   = 3'h2;
  localparam SRC_PWM_TWO   = 3'h3;
  localparam SRC_PWM_THREE = 3'h4;
  localparam SRC_PWM_FOUR  = 3'h5;
  localparam SRC_NUM_OSC   = 3'h6;
  localparam SRC_LOGIC     = 3'h7;

  // ****************************************
  // internal state and decode
  // ****************************************
  // next_ values are the combinational targets of the clocked processes

  reg                      src_raw;
  wire                     src_sync;
  wire                     fast_tick;
  wire                     db_tick;
  reg                      src_prev;
  reg [1:0]                state;
  reg [1:0]                next_state;
  reg [`CDG_DB_WIDTH-1:0]  rise_cnt;
  reg [`CDG_DB_WIDTH-1:0]  fall_cnt;
  reg [`CDG_DB_WIDTH-1:0]  next_rise_cnt;
  reg [`CDG_DB_WIDTH-1:0]  next_fall_cnt;
  reg                      drv_a;
  reg                      drv_b;
  reg                      next_drv_a;
  reg                      next_drv_b;
  reg                      lvl_a;
  reg                      lvl_b;
  wire                     rise_edge;
  wire                     fall_edge;

  // ****************************************
  // input source selection
  // ****************************************
  // eight-way source mux
  always @* begin
    case (input_source_select)
      SRC_CMP_ONE:   src_raw = comparator_one_sync_out;
      SRC_CMP_TWO:   src_raw = comparator_two_sync_out;
      SRC_PWM_ONE:   src_raw = pulse_gen_one_out;
      SRC_PWM_TWO:   src_raw = pulse_gen_two_out;
      SRC_PWM_THREE: src_raw = pulse_gen_three_out;
      SRC_PWM_FOUR:  src_raw = pulse_gen_four_out;
      SRC_NUM_OSC:   src_raw = numeric_oscillator_out;
      SRC_LOGIC:     src_raw = logic_cell_one_out;
      default: src_raw = 1'b0;
    endcase
  end

  // source is asynchronous; two flops before any edge logic
  // the mux sits ahead of the synchroniser so one pair of flops serves
  // all eight sources; a select change while enabled may show as an edge,
  // so software changes the select only with the module disabled
  cdg_sync u_src_sync (
    .clock     (clock),
    .reset_n   (reset_n),
    .level_in  (src_raw),
    .level_out (src_sync)
  );

  // ****************************************
  // dead-band clock
  // ****************************************
  // fast oscillator enable, or every system clock cycle
  // the divider is held in reset while disabled, so the tick phase at
  // enable is fixed; the edge itself still lands anywhere in a tick,
  // which is the one-tick uncertainty of the dead band
  cdg_tick u_tick (
    .clock   (clock),
    .reset_n (reset_n),
    .run     (module_enable),
    .tick    (fast_tick)
  );

  assign db_tick = (deadband_clock_select == `CDG_CLK_SEL_FAST) ? fast_tick : 1'b1;

  // ****************************************
  // edge detection
  // ****************************************
  // previous level; cleared by module disable so a high first level is seen as an edge
  // a source already high at enable therefore starts a rising dead band,
  // matching a start from both drives cleared
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      src_prev <= 1'b0;
    end else if (!module_enable) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_sync;
    end
  end

  assign rise_edge = src_sync & ~src_prev;
  assign fall_edge = ~src_sync & src_prev;

  // ****************************************
  // dead-band sequencer
  // ****************************************
  // edge starts its own counter, aborts the other; count hits register
  // value to switch the waiting output on
  // the output being switched off drops in the edge cycle itself, so the
  // two drives never overlap; an abort clears both counters, which keeps
  // a short pulse from ever reaching the waiting output
  // completion compares count plus one so that a value of n gives n ticks
  // and the sum never wraps for the largest six-bit value
  always @* begin
    next_state    = state;
    next_rise_cnt = rise_cnt;
    next_fall_cnt = fall_cnt;
    next_drv_a    = drv_a;
    next_drv_b    = drv_b;
    if (rise_edge) begin
      next_drv_b    = 1'b0;
      next_fall_cnt = `CDG_DB_RESET;
      next_rise_cnt = `CDG_DB_RESET;
      if (rising_deadtime_reg == `CDG_DB_RESET) begin
        next_drv_a = 1'b1;
        next_state = ST_IDLE;
      end else begin
        next_drv_a = 1'b0;
        next_state = ST_RISE;
      end
    end else if (fall_edge) begin
      next_drv_a    = 1'b0;
      next_rise_cnt = `CDG_DB_RESET;
      next_fall_cnt = `CDG_DB_RESET;
      if (falling_deadtime_reg == `CDG_DB_RESET) begin
        next_drv_b = 1'b1;
        next_state = ST_IDLE;
      end else begin
        next_drv_b = 1'b0;
        next_state = ST_FALL;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_RISE: begin
          if (db_tick) begin
            if (rise_cnt + 6'h01 >= rising_deadtime_reg) begin
              next_drv_a    = 1'b1;
              next_rise_cnt = `CDG_DB_RESET;
              next_state    = ST_IDLE;
            end else begin
              next_rise_cnt = rise_cnt + 6'h01;
            end
          end
        end
        ST_FALL: begin
          if (db_tick) begin
            if (fall_cnt + 6'h01 >= falling_deadtime_reg) begin
              next_drv_b    = 1'b1;
              next_fall_cnt = `CDG_DB_RESET;
              next_state    = ST_IDLE;
            end else begin
              next_fall_cnt = fall_cnt + 6'h01;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // sequencer registers; disable holds both drives cleared
  // disable acts as a functional reset, so enable always starts idle
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state    <= ST_IDLE;
      rise_cnt <= `CDG_DB_RESET;
      fall_cnt <= `CDG_DB_RESET;
      drv_a    <= 1'b0;
      drv_b    <= 1'b0;
    end else if (!module_enable) begin
      state    <= ST_IDLE;
      rise_cnt <= `CDG_DB_RESET;
      fall_cnt <= `CDG_DB_RESET;
      drv_a    <= 1'b0;
      drv_b    <= 1'b0;
    end else begin
      state    <= next_state;
      rise_cnt <= next_rise_cnt;
      fall_cnt <= next_fall_cnt;
      drv_a    <= next_drv_a;
      drv_b    <= next_drv_b;
    end
  end

  // status view of the running counter; idle reads zero
  assign deadband_count = (state == ST_FALL) ? fall_cnt : rise_cnt;
  assign deadband_busy  = (state != ST_IDLE);

  // ****************************************
  // output stage
  // ****************************************
  // polarity on waveform only; override bypasses polarity
  // override levels reach the pin as given, so a shutdown level stays
  // valid whatever polarity software has chosen
  always @* begin
    if (override_active) begin
      lvl_a = override_level_a;
      lvl_b = override_level_b;
    end else begin
      lvl_a = out_a_polarity ? drv_a : ~drv_a;
      lvl_b = out_b_polarity ? drv_b : ~drv_b;
    end
  end

  // registered pin drive and enables
  // pins come from flops so no mux glitch reaches a gate driver;
  // while disabled both enable and level read zero
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      primary_output       <= 1'b0;
      complement_output    <= 1'b0;
      primary_output_oe    <= 1'b0;
      complement_output_oe <= 1'b0;
    end else begin
      primary_output       <= module_enable & lvl_a;
      complement_output    <= module_enable & lvl_b;
      primary_output_oe    <= module_enable & out_a_pin_enable;
      complement_output_oe <= module_enable & out_b_pin_enable;
    end
  end

endmodule // cdg_gen

/* tb/cdg_gate_model.sv */
/*
 * gate driver model standing on the two output pins.
 * assumes released pins are pulled low on the board.
 */
module cdg_gate_model (
  input  wire logic pin_a,
  input  wire logic pin_a_oe,
  input  wire logic pin_b,
  input  wire logic pin_b_oe,
  output wire logic gate_a,
  output wire logic gate_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // undriven pins fall to the pull-down level
  assign gate_a = pin_a_oe ? pin_a : 1'b0;
  assign gate_b = pin_b_oe ? pin_b : 1'b0;
endmodule // cdg_gate_model

/* tb/cdg_gen_monitor.sv */
/*
 * port checker for cdg_gen, bound to every instance.
 * assumes control bits change only while module_enable is low.
 */
module cdg_monitor (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       module_enable,
  input wire logic       out_a_polarity,
  input wire logic       out_b_polarity,
  input wire logic       deadband_clock_select,
  input wire logic [5:0] rising_deadtime_reg,
  input wire logic [5:0] falling_deadtime_reg,
  input wire logic       override_active,
  input wire logic       override_level_a,
  input wire logic       override_level_b,
  input wire logic       primary_output,
  input wire logic       primary_output_oe,
  input wire logic       complement_output,
  input wire logic       complement_output_oe,
  input wire logic [5:0] deadband_count,
  input wire logic       deadband_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // a pin is on when driven at its active level
  wire a_on = primary_output_oe && (primary_output == out_a_polarity);
  wire b_on = complement_output_oe && (complement_output == out_b_polarity);
  // port properties
  property p_dis;
    !module_enable |=> !primary_output_oe && !complement_output_oe && !primary_output && !complement_output;
  endproperty
  property p_clr;
    $rose(module_enable) && !override_active |=> !a_on && !b_on;
  endproperty
  property p_ovr;
    (module_enable && override_active)[*3] |-> primary_output == override_level_a
      && complement_output == override_level_b;
  endproperty
  property p_nov;
    module_enable && !override_active && !$past(override_active) |-> !(a_on && b_on);
  endproperty
  property p_zero;
    module_enable && rising_deadtime_reg == 6'h00 && falling_deadtime_reg == 6'h00 |-> !deadband_busy;
  endproperty
  property p_rng;
    deadband_busy |-> deadband_count < rising_deadtime_reg || deadband_count < falling_deadtime_reg;
  endproperty
  property p_sys;
    !deadband_clock_select && deadband_busy && $past(deadband_busy) && deadband_count != 6'h00
      |-> deadband_count == $past(deadband_count) + 6'h01;
  endproperty
  property p_fast;
    deadband_clock_select && deadband_count == $past(deadband_count) + 6'h01
      |=> deadband_count != $past(deadband_count) + 6'h01;
  endproperty
  a_dis: assert property (p_dis)
    else $error("pins driven while disabled");
  a_clr: assert property (p_clr)
    else $error("pin on after enable");
  a_ovr: assert property (p_ovr)
    else $error("override level wrong");
  a_nov: assert property (p_nov)
    else $error("both pins on");
  a_zero: assert property (p_zero)
    else $error("busy with zero dead time");
  a_rng: assert property (p_rng)
    else $error("count beyond setting");
  a_sys: assert property (p_sys)
    else $error("count skipped a clock");
  a_fast: assert property (p_fast)
    else $error("fast count too quick");
  c_rise: cover property ($rose(a_on));
  c_ovr: cover property (module_enable && override_active);
  c_fast: cover property (deadband_clock_select && deadband_busy);
endmodule // cdg_monitor

bind cdg_gen cdg_monitor mon_u (.*);

/* tb/test_complementary_deadband_generator.sv */
/*
 * bench for cdg_gen with the gate model and the bound checker.
 * assumes a 40 MHz clock and control bits set only while disabled, apart from the A pin enable.
 */
module test_complementary_deadband_generator;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 1'b0;
  logic       reset_n = 1'b0;
  logic       en = 1'b0;
  logic       oea = 1'b1;
  logic       cs = 1'b0;
  logic       ovr = 1'b0;
  logic [1:0] pol = 2'h3;
  logic [1:0] ovl = 2'h0;
  logic [2:0] sel = 3'h0;
  logic [5:0] rdb = 6'h00;
  logic [5:0] fdb = 6'h00;
  logic [7:0] src = 8'h00;
  wire        po, poe, co, coe, ga, gb, busy;
  wire  [5:0] cnt;
  int         n_errors = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         n;

  cdg_gen dut_u (
    .clock(clock), .reset_n(reset_n), .module_enable(en), .out_a_pin_enable(oea), .out_b_pin_enable(1'b1),
    .out_a_polarity(pol[1]), .out_b_polarity(pol[0]), .deadband_clock_select(cs), .input_source_select(sel),
    .rising_deadtime_reg(rdb), .falling_deadtime_reg(fdb), .comparator_one_sync_out(src[0]),
    .comparator_two_sync_out(src[1]), .pulse_gen_one_out(src[2]), .pulse_gen_two_out(src[3]),
    .pulse_gen_three_out(src[4]), .pulse_gen_four_out(src[5]), .numeric_oscillator_out(src[6]),
    .logic_cell_one_out(src[7]), .override_active(ovr), .override_level_a(ovl[1]), .override_level_b(ovl[0]),
    .primary_output(po), .primary_output_oe(poe), .complement_output(co), .complement_output_oe(coe),
    .deadband_count(cnt), .deadband_busy(busy)
  );
  cdg_gate_model drv_u (.pin_a(po), .pin_a_oe(poe), .pin_b(co), .pin_b_oe(coe), .gate_a(ga), .gate_b(gb));

  // clock and hang guard
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic drive(input int s, input logic lv);
    @(posedge clock);
    src[s] <= lv;
    #1;
  endtask

  // cycles until a gate reaches a level
  task automatic wt(input logic b, input logic lv, output int k);
    k = 0;
    while (((b ? gb : ga) !== lv) && k < 300) begin
      @(posedge clock);
      #1;
      k++;
    end
  endtask

  task automatic setup(input logic [1:0] p, input logic c, input int s, input int r, input int f);
    @(posedge clock);
    en <= 1'b0;
    repeat (3) @(posedge clock);
    pol <= p;
    cs <= c;
    sel <= 3'(s);
    rdb <= 6'(r);
    fdb <= 6'(f);
    @(posedge clock);
    en <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // one full pulse so that the complement pin is on
  task automatic prime(input int s);
    drive(s, 1'b1);
    repeat (80) @(posedge clock);
    drive(s, 1'b0);
    repeat (80) @(posedge clock);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      setup(2'h3, 1'b0, s, s * 9, s * 8);
      chk({ga, gb}, 2'h0);
      prime(s);
      drive(s, 1'b1);
      wt(1'b1, 1'b0, n);
      chk(n, 4);
      wt(1'b0, 1'b1, n);
      chk(n, s * 9);
      drive(s, 1'b0);
      wt(1'b0, 1'b0, n);
      chk(n, 4);
      wt(1'b1, 1'b1, n);
      chk(n, s * 8);
    end
    $display("test edges done");
    setup(2'h3, 1'b0, 2, 20, 20);
    prime(2);
    drive(2, 1'b1);
    repeat (5) @(posedge clock);
    drive(2, 1'b0);
    n = 0;
    repeat (60) begin
      @(posedge clock);
      #1;
      n += (ga !== 1'b0);
    end
    chk(n, 0);
    $display("test abort done");
    setup(2'h3, 1'b1, 3, 16, 16);
    prime(3);
    drive(3, 1'b1);
    wt(1'b1, 1'b0, n);
    wt(1'b0, 1'b1, n);
    chk(n >= 37 && n <= 43, 1);
    $display("test fast clock done");
    setup(2'h1, 1'b0, 5, 2, 2);
    chk({po, co}, 2'h2);
    drive(5, 1'b1);
    repeat (10) @(posedge clock);
    chk({po, co}, 2'h0);
    ovl <= 2'h1;
    ovr <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk({po, co}, 2'h1);
    @(posedge clock);
    ovr <= 1'b0;
    oea <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk({poe, coe}, 2'h1);
    @(posedge clock);
    en <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk({poe, coe, po, co}, 4'h0);
    $display("test pins done");
    end_sim();
  end
endmodule // test_complementary_deadband_generator
